// ---- hw/amsq_pkg.sv ----
// package for the asynchronous memory strobe sequencer: widths, reset values,
// phase constants, configuration and request carriers, sequencer states.
// assumes one system clock; all phase lengths are counted in interface ticks.
`default_nettype none
package amsq_pkg;
   localparam int WORD_ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int BA_W = 2;
   localparam int CS_W = 4;
   localparam int CS_IDX_W = 2;
   localparam int FIELD_W = 8;
   localparam int WCNT_W = 9;

   // timing of the extended wait, in ticks
   localparam logic [FIELD_W-1:0] WAIT_BLOCK_TICKS = 8'h10;
   localparam logic [FIELD_W-1:0] WAIT_RELEASE_TICKS = 8'h04;
   // largest number of counted wait cycles; a zero limit field selects it
   localparam logic [WCNT_W-1:0] WCNT_MAX = 9'h100;

   // values after reset
   localparam logic [CS_W-1:0] CS_IDLE_N = 4'hf;
   localparam logic [FIELD_W-1:0] CNT_RST = 8'h00;
   localparam logic [WCNT_W-1:0] WCNT_RST = 9'h000;
   localparam logic [WORD_ADDR_W-1:0] ADDR_RST = 21'h000000;
   localparam logic [BA_W-1:0] BA_RST = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   typedef struct packed {
      logic [FIELD_W-1:0] turnaround_cycles;
      logic [FIELD_W-1:0] read_setup_cycles;
      logic [FIELD_W-1:0] read_strobe_cycles;
      logic [FIELD_W-1:0] read_hold_cycles;
      logic [FIELD_W-1:0] write_setup_cycles;
      logic [FIELD_W-1:0] write_strobe_cycles;
      logic [FIELD_W-1:0] write_hold_cycles;
      logic [FIELD_W-1:0] max_wait_count;
      logic [CS_W-1:0] ext_wait_enable;
      logic strobe_select;
      logic half_rate;
   } amsq_cfg_t;

   typedef struct packed {
      logic write;
      logic [CS_IDX_W-1:0] region;
      logic [WORD_ADDR_W-1:0] word_addr;
      logic [BA_W-1:0] byte_lane_addr;
      logic [DATA_W-1:0] wdata;
   } amsq_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic timeout;
      logic [WCNT_W-1:0] ext_wait_count;
   } amsq_resp_t;

   localparam amsq_resp_t RESP_RST = '{rdata: DATA_RST, timeout: 1'b0, ext_wait_count: WCNT_RST};

   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_SETUP   = 7'h02,
      ST_STROBE  = 7'h04,
      ST_WAIT    = 7'h08,
      ST_RELEASE = 7'h10,
      ST_HOLD    = 7'h20,
      ST_TURN    = 7'h40
   } amsq_state_t;
endpackage : amsq_pkg
`default_nettype wire

// ---- hw/amsq_tick_sync.sv ----
// interface tick generator and synchroniser for the external wait pin.
// assumes restart is a one-cycle pulse from the sequencer when an access is taken.
`default_nettype none
module amsq_tick_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic half_rate,
   input wire logic restart,
   // external wait pin, asynchronous
   input wire logic ext_wait_in,
   // to the sequencer
   output logic tick,
   output logic wait_sync
);
   import amsq_pkg::*;

   logic tick_ff;
   logic meta_ff;
   logic wait_ff;
   logic nxt_tick;

   // restart aligns the half-rate phase so a phase always spans whole ticks
   assign nxt_tick = restart ? ~half_rate : (half_rate ? ~tick_ff : 1'b1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= nxt_tick;
      end
   end

   // two-stage synchroniser; only wait_ff is looked at downstream
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 1'b0;
         wait_ff <= 1'b0;
      end else begin
         meta_ff <= ext_wait_in;
         wait_ff <= meta_ff;
      end
   end

   assign tick = tick_ff;
   assign wait_sync = wait_ff;
endmodule : amsq_tick_sync
`default_nettype wire

// ---- hw/amsq_sequencer.sv ----
// strobe sequencer for an external asynchronous sram or nor memory port.
// assumes requests come from on-chip logic on clk, and that the memory
// side is asynchronous; only ext_wait_in is sampled through a synchroniser.
//
// Contract
// - read: address and byte lanes valid read-setup ticks before read strobe falls
// - read: address and byte lanes held read-hold ticks after read strobe rises
// - wait off: read strobe low exactly read-strobe ticks
// - wait on: read strobe low adds sixteen ticks per counted wait cycle
// - read strobe rises four ticks after wait input drops
// - write lasts setup plus strobe plus hold, plus sixteen per wait cycle
// - write: chip select leads write strobe by setup, or falls with it
// - write: chip select trails write strobe by hold, or rises with it
// - write: byte lanes valid write-setup ticks before write strobe falls
// - write: word address valid write-setup ticks before write strobe falls
// - write: address and byte lanes held write-hold ticks after strobe rises
// - write strobe low is strobe ticks, plus sixteen per wait cycle
// - write strobe rises four ticks after wait input drops
// - write data driven write-setup ticks before write strobe falls
// - write data kept driven write-hold ticks after write strobe rises
// - one tick is one clock at full rate, two at half rate
// - setup, strobe, hold, turnaround and the wait limit come from programmable fields; wait block and release are fixed
// - wait cycles count up to 256; the programmed limit ends waiting
// - read lasts setup plus strobe plus hold ticks with wait off
// - read: chip select leads read strobe by setup, or falls with it
`default_nettype none
module amsq_sequencer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration, held stable while an access runs
   input wire amsq_pkg::amsq_cfg_t cfg,
   // request
   input wire logic req_valid,
   input wire amsq_pkg::amsq_req_t req,
   output logic req_ready,
   // response
   output logic resp_valid,
   output amsq_pkg::amsq_resp_t resp,
   // memory pins
   input wire logic ext_wait_in,
   output logic [amsq_pkg::CS_W-1:0] chip_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic [amsq_pkg::WORD_ADDR_W-1:0] word_addr,
   output logic [amsq_pkg::BA_W-1:0] byte_lane_addr,
   input wire logic [amsq_pkg::DATA_W-1:0] data_bus_in,
   output logic [amsq_pkg::DATA_W-1:0] data_bus_out,
   output logic data_bus_oe
);
   import amsq_pkg::*;

   // last count value of a phase; a zero field still gives one tick
   function automatic logic [FIELD_W-1:0] last_of(input logic [FIELD_W-1:0] n);
      last_of = (n == CNT_RST) ? CNT_RST : n - 8'h01;
   endfunction : last_of

   function automatic logic [CS_W-1:0] region_sel_n(input logic [CS_IDX_W-1:0] idx);
      region_sel_n = ~(4'h1 << idx);
   endfunction : region_sel_n

   // strobe is low in these states, read or write alike
   function automatic logic in_strobe(input amsq_state_t s);
      in_strobe = (s == ST_STROBE) || (s == ST_WAIT) || (s == ST_RELEASE);
   endfunction : in_strobe

   amsq_state_t state_ff;
   amsq_state_t nxt_state;
   logic [FIELD_W-1:0] cnt_ff;
   logic [FIELD_W-1:0] nxt_cnt;
   logic [WCNT_W-1:0] wcnt_ff;
   logic [WCNT_W-1:0] nxt_wcnt;
   logic timeout_ff;
   logic nxt_timeout;
   amsq_req_t req_ff;
   logic req_ready_ff;
   logic resp_valid_ff;
   amsq_resp_t resp_ff;
   logic [CS_W-1:0] cs_n_ff;
   logic rd_n_ff;
   logic wr_n_ff;
   logic [WORD_ADDR_W-1:0] addr_ff;
   logic [BA_W-1:0] ba_ff;
   logic [DATA_W-1:0] dout_ff;
   logic doe_ff;

   logic tick;
   logic wait_sync;
   logic accept;
   logic wait_hit;
   logic is_wr;
   logic [FIELD_W-1:0] setup_len;
   logic [FIELD_W-1:0] strobe_len;
   logic [FIELD_W-1:0] hold_len;
   logic [FIELD_W-1:0] phase_len;
   logic phase_done;
   logic [WCNT_W-1:0] wcnt_inc;
   logic [WCNT_W-1:0] wcnt_limit;
   logic strobe_phase_nxt;
   logic cs_phase_nxt;
   logic cs_on_nxt;
   logic [CS_W-1:0] nxt_cs_n;
   logic nxt_rd_n;
   logic nxt_wr_n;
   logic nxt_doe;
   logic strobe_end;
   logic nxt_resp_valid;

   amsq_tick_sync amsq_tick_sync_inst (
      .clk(clk),
      .rst_n(rst_n),
      .half_rate(cfg.half_rate),
      .restart(accept),
      .ext_wait_in(ext_wait_in),
      .tick(tick),
      .wait_sync(wait_sync)
   );

   // request taken on any clock while idle, except the first after reset; tick phase restarts with it
   assign accept = req_valid && req_ready_ff;
   assign is_wr = req_ff.write;

   // a region with wait disabled never sees the pin
   assign wait_hit = wait_sync && cfg.ext_wait_enable[req_ff.region];

   // phase lengths per direction, all from programmed fields
   assign setup_len = is_wr ? cfg.write_setup_cycles : cfg.read_setup_cycles;
   assign strobe_len = is_wr ? cfg.write_strobe_cycles : cfg.read_strobe_cycles;
   assign hold_len = is_wr ? cfg.write_hold_cycles : cfg.read_hold_cycles;

   assign phase_len = (state_ff == ST_SETUP) ? setup_len :
                      (state_ff == ST_STROBE) ? strobe_len :
                      (state_ff == ST_WAIT) ? WAIT_BLOCK_TICKS :
                      (state_ff == ST_RELEASE) ? WAIT_RELEASE_TICKS :
                      (state_ff == ST_HOLD) ? hold_len :
                      cfg.turnaround_cycles;

   // a zero field still ends on the first tick, so no phase is ever skipped
   assign phase_done = tick && (cnt_ff == last_of(phase_len));

   // each wait block of sixteen ticks is one counted wait cycle
   assign wcnt_inc = wcnt_ff + 9'h001;
   // limitation: the limit is compared after the increment, so even a limit
   // of one spends a full wait block before the timeout
   assign wcnt_limit = (cfg.max_wait_count == CNT_RST) ? WCNT_MAX :
                       {1'b0, cfg.max_wait_count};

   always_comb begin
      nxt_state = state_ff;
      nxt_wcnt = wcnt_ff;
      nxt_timeout = timeout_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_state = ST_SETUP;
               nxt_wcnt = WCNT_RST;
               nxt_timeout = 1'b0;
            end
         end
         ST_SETUP: begin
            if (phase_done) begin
               nxt_state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            // wait must already be seen where hold would otherwise begin
            if (phase_done) begin
               nxt_state = wait_hit ? ST_WAIT : ST_HOLD;
            end
         end
         ST_WAIT: begin
            // a drop and a block end in one tick: the drop wins, the block is not counted
            if (tick && !wait_hit) begin
               nxt_state = ST_RELEASE;
            end else if (phase_done) begin
               nxt_wcnt = wcnt_inc;
               if (wcnt_inc == wcnt_limit) begin
                  nxt_timeout = 1'b1;
                  nxt_state = ST_HOLD;
               end
            end
         end
         ST_RELEASE: begin
            if (phase_done) begin
               nxt_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (phase_done) begin
               nxt_state = ST_TURN;
            end
         end
         ST_TURN: begin
            if (phase_done) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // counter restarts on every phase change and at each wait block end
   assign nxt_cnt = ((nxt_state != state_ff) || phase_done) ? CNT_RST :
                    tick ? cnt_ff + 8'h01 : cnt_ff;

   // pin levels for the coming cycle
   assign strobe_phase_nxt = in_strobe(nxt_state);
   assign cs_phase_nxt = strobe_phase_nxt || (nxt_state == ST_SETUP) ||
                         (nxt_state == ST_HOLD);
   // strobe-select mode collapses chip select onto the strobe window
   assign cs_on_nxt = cfg.strobe_select ? strobe_phase_nxt : cs_phase_nxt;
   assign nxt_cs_n = cs_on_nxt ? region_sel_n(accept ? req.region : req_ff.region) :
                     CS_IDLE_N;
   assign nxt_rd_n = !(strobe_phase_nxt && !is_wr);
   assign nxt_wr_n = !(strobe_phase_nxt && is_wr);
   // data driven from setup through hold of a write only
   assign nxt_doe = accept ? req.write :
                    (cs_phase_nxt && is_wr);

   assign strobe_end = !strobe_phase_nxt && in_strobe(state_ff);
   assign nxt_resp_valid = (state_ff == ST_HOLD) && phase_done;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         cnt_ff <= CNT_RST;
         wcnt_ff <= WCNT_RST;
         timeout_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wcnt_ff <= nxt_wcnt;
         timeout_ff <= nxt_timeout;
      end
   end

   // request and address are captured once and stand until the next access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ff <= '0;
         addr_ff <= ADDR_RST;
         ba_ff <= BA_RST;
         dout_ff <= DATA_RST;
      end else if (accept) begin
         req_ff <= req;
         addr_ff <= req.word_addr;
         ba_ff <= req.byte_lane_addr;
         dout_ff <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_n_ff <= CS_IDLE_N;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         doe_ff <= 1'b0;
         req_ready_ff <= 1'b0;
      end else begin
         cs_n_ff <= nxt_cs_n;
         rd_n_ff <= nxt_rd_n;
         wr_n_ff <= nxt_wr_n;
         doe_ff <= nxt_doe;
         // ready drops on the taking edge, so a request held a clock too long is not taken twice
         req_ready_ff <= (nxt_state == ST_IDLE);
      end
   end

   // read data sampled on the clock that raises the read strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_ff <= RESP_RST;
         resp_valid_ff <= 1'b0;
      end else begin
         resp_valid_ff <= nxt_resp_valid;
         if (strobe_end && !is_wr) begin
            resp_ff.rdata <= data_bus_in;
         end
         if (nxt_resp_valid) begin
            resp_ff.timeout <= timeout_ff;
            resp_ff.ext_wait_count <= wcnt_ff;
         end
      end
   end

   // every output comes straight from a flip-flop, so the pins never glitch
   assign req_ready = req_ready_ff;
   assign resp_valid = resp_valid_ff;
   assign resp = resp_ff;
   assign chip_select_n = cs_n_ff;
   assign read_strobe_n = rd_n_ff;
   assign write_strobe_n = wr_n_ff;
   assign word_addr = addr_ff;
   assign byte_lane_addr = ba_ff;
   assign data_bus_out = dout_ff;
   assign data_bus_oe = doe_ff;
endmodule : amsq_sequencer
`default_nettype wire

// ---- test/amsq_sequencer_props.sv ----
// checker for the strobe sequencer pins, bound to the top module.
// assumes cfg is held stable while an access runs.
`default_nettype none
module amsq_sequencer_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration and memory pins
   input wire amsq_pkg::amsq_cfg_t cfg,
   input wire logic ext_wait_in,
   input wire logic [amsq_pkg::CS_W-1:0] chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [amsq_pkg::WORD_ADDR_W-1:0] word_addr,
   input wire logic [amsq_pkg::BA_W-1:0] byte_lane_addr,
   input wire logic [amsq_pkg::DATA_W-1:0] data_bus_out,
   input wire logic data_bus_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   import amsq_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_strobe_fell;
      $fell(read_strobe_n) || $fell(write_strobe_n);
   endsequence
   sequence s_wait_drop;
      $fell(ext_wait_in) && !(read_strobe_n && write_strobe_n);
   endsequence
   property p_cs_lead;
      s_strobe_fell ##0 !cfg.strobe_select |-> $past(chip_select_n) != CS_IDLE_N;
   endproperty
   a_cs_lead: assert property (p_cs_lead) else $error("select late");
   property p_cs_with;
      cfg.strobe_select && read_strobe_n && write_strobe_n |-> chip_select_n == CS_IDLE_N;
   endproperty
   a_cs_with: assert property (p_cs_with) else $error("select apart");
   property p_cs_hold;
      $rose(write_strobe_n) && !cfg.strobe_select |-> chip_select_n != CS_IDLE_N;
   endproperty
   a_cs_hold: assert property (p_cs_hold) else $error("select early off");
   property p_addr_setup;
      s_strobe_fell |-> $stable(word_addr) && $stable(byte_lane_addr);
   endproperty
   a_addr_setup: assert property (p_addr_setup) else $error("addr setup");
   property p_addr_hold;
      $rose(read_strobe_n) || $rose(write_strobe_n) |-> $stable(word_addr) && $stable(byte_lane_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("addr hold");
   property p_wdata_setup;
      $fell(write_strobe_n) |-> data_bus_oe && $past(data_bus_oe) && $stable(data_bus_out);
   endproperty
   a_wdata_setup: assert property (p_wdata_setup) else $error("data setup");
   property p_wdata_hold;
      $rose(write_strobe_n) |-> data_bus_oe && $stable(data_bus_out);
   endproperty
   a_wdata_hold: assert property (p_wdata_hold) else $error("data hold");
   property p_half_tick;
      cfg.half_rate && ($fell(read_strobe_n) || $fell(write_strobe_n))
         |=> !(read_strobe_n && write_strobe_n);
   endproperty
   a_half_tick: assert property (p_half_tick) else $error("half tick");
   property p_wait_rel;
      s_wait_drop |-> ##[1:12] (read_strobe_n && write_strobe_n);
   endproperty
   a_wait_rel: assert property (p_wait_rel) else $error("wait release");
endmodule : amsq_sequencer_props
bind amsq_sequencer amsq_sequencer_props amsq_sequencer_props_inst (.clk(clk), .rst_n(rst_n),
   .cfg(cfg), .ext_wait_in(ext_wait_in), .chip_select_n(chip_select_n),
   .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .word_addr(word_addr),
   .byte_lane_addr(byte_lane_addr), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
`default_nettype wire

// ---- test/amsq_mem_model.sv ----
// memory model: 16 words behind the strobes, plus a commanded wait pulse.
// assumes wait_len is zero or at least four clocks.
`default_nettype none
module amsq_mem_model (
   // clock
   input wire logic clk,
   // memory pins
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [amsq_pkg::WORD_ADDR_W-1:0] word_addr,
   input wire logic [amsq_pkg::DATA_W-1:0] data_bus_out,
   output logic [amsq_pkg::DATA_W-1:0] data_bus_in,
   output logic ext_wait_in,
   // wait pulse length in clocks
   input wire logic [15:0] wait_len
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [16];
   logic [15:0] last_ff = 16'h0000;
   logic [15:0] cnt_ff = 16'h0000;
   logic low_ff = 1'b0;
   initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
   // a released bus shows the inverse of its last value, never a stale word
   assign data_bus_in = read_strobe_n ? ~last_ff : mem[word_addr[3:0]];
   assign ext_wait_in = cnt_ff != 16'h0000;
   always @(posedge clk) begin
      last_ff <= data_bus_in;
      low_ff <= !(read_strobe_n && write_strobe_n);
      // raised at strobe start, well before the hold phase would begin
      if (!low_ff && !(read_strobe_n && write_strobe_n)) cnt_ff <= wait_len;
      else if (cnt_ff != 16'h0000) cnt_ff <= cnt_ff - 16'h0001;
      if (!write_strobe_n) mem[word_addr[3:0]] <= data_bus_out;
   end
endmodule : amsq_mem_model
`default_nettype wire

// ---- test/amsq_sequencer_tb.sv ----
// bench for the strobe sequencer: random and corner accesses, phases timed at the pins.
// assumes the memory model starts with all words zero.
`default_nettype none
module amsq_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import amsq_pkg::*;
   logic clk, rst_n, req_valid, req_ready, resp_valid, ext_wait_in, rd_n, wr_n, oe;
   amsq_cfg_t cfg;
   amsq_req_t req;
   amsq_resp_t resp;
   logic [CS_W-1:0] chip_select_n;
   logic [WORD_ADDR_W-1:0] word_addr;
   logic [BA_W-1:0] byte_lane_addr;
   logic [DATA_W-1:0] din, dout;
   logic [15:0] wait_len;
   logic [15:0] shadow [16];
   int bad_count, num_checks, su, st, hd;
   integer seed = 32'hbac78c63;
   amsq_sequencer amsq_sequencer_inst (.clk(clk), .rst_n(rst_n), .cfg(cfg),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp(resp), .ext_wait_in(ext_wait_in), .chip_select_n(chip_select_n),
      .read_strobe_n(rd_n), .write_strobe_n(wr_n), .word_addr(word_addr),
      .byte_lane_addr(byte_lane_addr), .data_bus_in(din), .data_bus_out(dout),
      .data_bus_oe(oe));
   amsq_mem_model amsq_mem_model_inst (.clk(clk), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
      .word_addr(word_addr), .data_bus_out(dout), .data_bus_in(din),
      .ext_wait_in(ext_wait_in), .wait_len(wait_len));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   // a zero field still costs one tick
   function automatic int ticks(input logic [7:0] n);
      return (n == 8'h00 ? 1 : int'(n)) * (cfg.half_rate ? 2 : 1);
   endfunction : ticks
   function automatic logic [7:0] rf();
      return {6'h00, 2'($random(seed))};
   endfunction : rf
   // one access; cycles are sampled mid-cycle, clear of the launching edge
   task automatic access(input amsq_req_t r);
      logic low, ok, sn;
      low = 1'b0;
      ok = 1'b1;
      su = 0;
      st = 0;
      hd = 0;
      @(negedge clk);
      req = r;
      req_valid = 1'b1;
      repeat (600) begin
         @(posedge clk);
         if (req_ready === 1'b1) break;
      end
      @(negedge clk);
      req_valid = 1'b0;
      repeat (3000) begin
         if (resp_valid === 1'b1) break;
         sn = r.write ? wr_n : rd_n;
         if (chip_select_n[r.region] === 1'b0 && sn === 1'b1) begin
            if (low) hd++;
            else su++;
         end
         if (sn === 1'b0) begin
            st++;
            low = 1'b1;
         end
         if (chip_select_n[r.region] === 1'b0 && (word_addr !== r.word_addr ||
            byte_lane_addr !== r.byte_lane_addr || (!r.write && oe !== 1'b0) ||
            (r.write && {oe, dout} !== {1'b1, r.wdata})))
            ok = 1'b0;
         @(negedge clk);
      end
      check(resp_valid, 1'b1);
      check(ok, 1'b1);
      // cfg may only change once the turnaround is over
      repeat (600) begin
         if (req_ready === 1'b1) break;
         @(negedge clk);
      end
   endtask : access
   task automatic plain(input amsq_req_t r);
      logic [7:0] s, t, h;
      s = r.write ? cfg.write_setup_cycles : cfg.read_setup_cycles;
      t = r.write ? cfg.write_strobe_cycles : cfg.read_strobe_cycles;
      h = r.write ? cfg.write_hold_cycles : cfg.read_hold_cycles;
      access(r);
      check(su, cfg.strobe_select ? 0 : ticks(s));
      check(st, ticks(t));
      check(hd, cfg.strobe_select ? 0 : ticks(h));
      if (!cfg.strobe_select) check(su + st + hd, ticks(s) + ticks(t) + ticks(h));
      if (r.write) shadow[r.word_addr[3:0]] = r.wdata;
      else check(resp.rdata, shadow[r.word_addr[3:0]]);
   endtask : plain
   // access with a wait pulse; the pin must be low again before the next one
   task automatic waited(input amsq_req_t r, input logic [15:0] wl);
      wait_len = wl;
      access(r);
      wait_len = 16'h0000;
      repeat (400) begin
         if (ext_wait_in === 1'b0) break;
         @(negedge clk);
      end
   endtask : waited
   // the longest test needs well under 20000 cycles
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      wait_len = 16'h0000;
      bad_count = 0;
      num_checks = 0;
      cfg = '{8'h01, 8'h02, 8'h08, 8'h01, 8'h02, 8'h08, 8'h01, 8'h00, 4'h1, 1'b0, 1'b0};
      for (int i = 0; i < 16; i++) shadow[i] = 16'h0000;
      repeat (6) @(posedge clk);
      @(negedge clk);
      check({chip_select_n, rd_n, wr_n, oe, req_ready, resp_valid}, {CS_IDLE_N, 5'b11000});
      rst_n = 1'b1;
      waited('{1'b0, 2'h0, 21'h000005, 2'h1, 16'h0000}, 16'h0028);
      check(resp.timeout, 1'b0);
      check(st > 8, 1'b1);
      check(resp.ext_wait_count, 9'h002);
      waited('{1'b1, 2'h0, 21'h000006, 2'h2, 16'h5a5a}, 16'h0028);
      check(st > 8, 1'b1);
      waited('{1'b0, 2'h1, 21'h000007, 2'h0, 16'h0000}, 16'h0028);
      check(st, 8);
      check(resp.timeout, 1'b0);
      cfg.max_wait_count = 8'h02;
      waited('{1'b0, 2'h0, 21'h000008, 2'h3, 16'h0000}, 16'h012c);
      check(resp.timeout, 1'b1);
      check(resp.ext_wait_count, 9'h002);
      shadow[6] = 16'h5a5a;
      cfg = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 4'h0, 1'b0, 1'b0};
      plain('{1'b1, 2'h3, 21'h1fffff, 2'h3, 16'hffff});
      for (int i = 0; i < 30; i++) begin
         cfg = '{rf(), rf(), rf(), rf(), rf(), rf(), rf(), 8'h00, 4'($random(seed)),
            1'($random(seed)), 1'($random(seed))};
         plain('{1'($random(seed)), 2'($random(seed)), 21'($random(seed)),
            2'($random(seed)), 16'($random(seed))});
      end
      complete_run();
   end
endmodule : amsq_sequencer_tb
`default_nettype wire
